// ---- test/ffs_plant.sv ----
// Switching stage model: cycle and PWM falling-edge pulses
`timescale 1ns/1ns
module ffs_plant (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic gate_en,
  output logic sw_cycle,
  output logic pwm_fall
);
  logic [1:0] ph_q;
  logic [1:0] ph_d;

  // Four clocks per switching cycle, held at phase zero while the gate is off
  always_comb begin
    ph_d = (sys_rst || !gate_en) ? 2'h0 : ph_q + 2'h1;
  end

  always_ff @(posedge clk) begin
    ph_q <= ph_d;
  end

  // Pulses only while the switch is being driven
  assign sw_cycle = gate_en && ph_q == 2'h3;
  assign pwm_fall = gate_en && ph_q == 2'h1;
endmodule : ffs_plant

// ---- test/tb_top.sv ----
// Self-checking bench for the fault supervisor
`timescale 1ns/1ns
module tb_top;
  import ffs_pkg::*;
  localparam int BO = 100;
  logic clk, sys_rst, sw_cycle, pwm_fall, latched_opt, variant_bo;
  logic gate_en_q, offset_en_q;
  logic [7:0] trim_q;
  ffs_cmp_t cmp;
  ffs_fault_t fault_q;
  ffs_state_t state_q;
  int errors, num_checks;

  ffs_supervisor #(.OPP_CYCLES(200), .BO_CYCLES(BO),
    .DITHER_STEP_CYCLES(4)) i_dut (.clk(clk), .sys_rst(sys_rst),
    .cmp(cmp), .sw_cycle(sw_cycle), .pwm_fall(pwm_fall),
    .latched_opt(latched_opt), .variant_bo(variant_bo),
    .gate_en_q(gate_en_q), .offset_en_q(offset_en_q),
    .fault_q(fault_q), .state_q(state_q), .trim_q(trim_q));

  ffs_plant i_plant (.clk(clk), .sys_rst(sys_rst), .gate_en(gate_en_q),
    .sw_cycle(sw_cycle), .pwm_fall(pwm_fall));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Compare tasks, one per kind of result
  task automatic chk1(string nm, logic exp, logic got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %b seen %b", nm, exp, got);
    end
  endtask : chk1

  task automatic chk_st(ffs_state_t exp);
    num_checks++;
    if (state_q !== exp) begin
      errors++;
      $display("unexpected state_q: expected %b seen %b", exp, state_q);
    end
  endtask : chk_st

  task automatic chk8(string nm, logic [7:0] exp, logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %0d seen %0d", nm, exp, got);
    end
  endtask : chk8

  task automatic clks(int n);
    repeat (n) @(posedge clk);
  endtask : clks

  task automatic ticks(int n);
    repeat (n) @(posedge clk iff sw_cycle);
  endtask : ticks

  // Bit-wise updates so pending single-bit changes are not undone
  task automatic set_pair(int hi, logic a, logic b);
    cmp[hi] <= a;
    cmp[hi - 1] <= b;
  endtask : set_pair

  task automatic do_reset(logic lat, logic vbo);
    clks(1);
    sys_rst <= 1'b1;
    latched_opt <= lat;
    variant_bo <= vbo;
    cmp <= '0;
    clks(10);
    chk_st(FFS_OFF);
    sys_rst <= 1'b0;
    clks(3);
    chk1("gate_en_q", 1'b0, gate_en_q);
    set_pair(11, 1'b1, 1'b0);
    clks(3);
  endtask : do_reset

  // Qualifier: early drop restarts, full count trips the fault
  task automatic qual(int ci, int fi, int n, string nm);
    cmp[ci] <= 1'b1;
    ticks(n - 1);
    cmp[ci] <= 1'b0;
    clks(2);
    cmp[ci] <= 1'b1;
    ticks(n - 1);
    chk1(nm, 1'b0, fault_q[fi]);
    chk1("gate_en_q", 1'b1, gate_en_q);
    ticks(1);
    clks(3);
    cmp[ci] <= 1'b0;
    chk1(nm, 1'b1, fault_q[fi]);
    chk1("gate_en_q", 1'b0, gate_en_q);
    chk_st(FFS_FAULT);
  endtask : qual

  // Supply falls to turn-off and rises again to turn-on
  task automatic cycle_vdd(ffs_state_t st, logic g);
    set_pair(11, 1'b0, 1'b1);
    clks(4);
    chk_st(st);
    chk1("fault_q", 1'b0, |fault_q);
    set_pair(11, 1'b1, 1'b0);
    clks(3);
    chk1("gate_en_q", g, gate_en_q);
  endtask : cycle_vdd

  task automatic test_dis();
    cmp.flt_dis <= 1'b1;
    clks(2);
    chk1("gate_en_q", 1'b0, gate_en_q);
    cmp.flt_dis <= 1'b0;
    chk1("fault_q.disabled", 1'b1, fault_q.disabled);
    clks(2);
    chk1("gate_en_q", 1'b1, gate_en_q);
  endtask : test_dis

  // Overpower timer: floor at zero, net accumulation, trip
  task automatic test_opp();
    set_pair(7, 1'b0, 1'b1);
    clks(300);
    set_pair(7, 1'b1, 1'b0);
    clks(120);
    set_pair(7, 1'b0, 1'b1);
    clks(100);
    set_pair(7, 1'b1, 1'b0);
    clks(150);
    chk1("gate_en_q", 1'b1, gate_en_q);
    clks(70);
    chk1("fault_q.opp", 1'b1, fault_q.opp);
    chk1("gate_en_q", 1'b0, gate_en_q);
  endtask : test_opp

  // Triangle between 0 and 50 permille in unit steps
  task automatic test_dither();
    logic [7:0] mx, mn, pv, d, bad;
    mx = 8'h00;
    mn = 8'hFF;
    bad = 8'h00;
    pv = trim_q;
    repeat (900) begin
      clks(1);
      d = trim_q - pv;
      if (d > 8'h01 && d != 8'hFF) bad++;
      if (trim_q > mx) mx = trim_q;
      if (trim_q < mn) mn = trim_q;
      pv = trim_q;
    end
    chk8("trim_q max", 8'h32, mx);
    chk8("trim_q min", 8'h00, mn);
    chk8("trim_q jumps", 8'h00, bad);
  endtask : test_dither

  // Brown-in arming, glitch rejection, qualification and release
  task automatic test_bo();
    clks(5);
    chk1("offset_en_q", 1'b0, offset_en_q);
    chk1("gate_en_q", 1'b0, gate_en_q);
    set_pair(4, 1'b1, 1'b0);
    clks(3);
    chk1("offset_en_q", 1'b1, offset_en_q);
    set_pair(4, 1'b0, 1'b1);
    clks(BO - 10);
    set_pair(4, 1'b1, 1'b0);
    clks(2);
    set_pair(4, 1'b0, 1'b1);
    clks(BO - 4);
    chk1("gate_en_q", 1'b1, gate_en_q);
    clks(8);
    chk1("gate_en_q", 1'b0, gate_en_q);
    chk1("fault_q.brown_out", 1'b1, fault_q.brown_out);
    set_pair(4, 1'b1, 1'b0);
    clks(3);
    chk1("gate_en_q", 1'b1, gate_en_q);
    cmp.flt_ovp <= 1'b1;
    ticks(6);
    chk1("fault_q.flt_ovp", 1'b0, fault_q.flt_ovp);
    chk1("gate_en_q", 1'b1, gate_en_q);
  endtask : test_bo

  task automatic finish_test();
    if (errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  // Watchdog, well beyond the expected run length
  initial begin
    #300000;
    errors++;
    finish_test();
  end

  // Main sequence
  initial begin
    errors = 0;
    num_checks = 0;
    sys_rst = 1'b1;
    latched_opt = 1'b0;
    variant_bo = 1'b0;
    cmp = '0;
    do_reset(1'b0, 1'b0);
    chk_st(FFS_RUN);
    test_dither();
    qual(9, 7, 3, "fault_q.vdd_ovlo");
    cycle_vdd(FFS_OFF, 1'b1);
    qual(8, 6, 32, "fault_q.die_ot");
    cycle_vdd(FFS_OFF, 1'b1);
    qual(5, 4, 8, "fault_q.scp");
    cycle_vdd(FFS_OFF, 1'b1);
    qual(2, 3, 3, "fault_q.flt_ovp");
    cycle_vdd(FFS_OFF, 1'b1);
    qual(1, 2, 32, "fault_q.flt_ot");
    cycle_vdd(FFS_OFF, 1'b1);
    test_dis();
    test_opp();
    cycle_vdd(FFS_OFF, 1'b1);
    do_reset(1'b1, 1'b0);
    qual(8, 6, 32, "fault_q.die_ot");
    cycle_vdd(FFS_LOCK, 1'b0);
    do_reset(1'b0, 1'b1);
    test_bo();
    finish_test();
  end
endmodule : tb_top

// ---- verilog/ffs_cycle_qual.sv ----
// Consecutive switching-cycle qualifier for one comparator
`timescale 1ns/1ns
module ffs_cycle_qual
  import ffs_pkg::*;
#(
  parameter int unsigned COUNT = 3,
  parameter int W = $clog2(COUNT + 1)
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clr,
  input wire logic tick,
  input wire logic level,
  output logic hit_q
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic hit_d;

  // Count cycles while indication holds, restart when it drops
  always_comb begin
    cnt_d = cnt_q;
    if (clr || !level) begin
      cnt_d = '0;
    end else if (tick && cnt_q != W'(COUNT)) begin
      cnt_d = cnt_q + W'(1);
    end
    hit_d = level && !clr && (cnt_d == W'(COUNT));
  end

  // Register counter and qualified result
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= '0;
      hit_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      hit_q <= hit_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  qual_restart_a:
  assert property (!level |=> cnt_q == '0 && !hit_q)
    else $error("qualifier did not restart on dropped level");

  qual_cause_a:
  assert property ($rose(hit_q) |-> $past(level) && $past(tick))
    else $error("qualifier hit without level and tick");

endmodule : ffs_cycle_qual

// ---- verilog/ffs_dither.sv ----
// Triangular switching-frequency dither generator
`timescale 1ns/1ns
`include "ffs_map.svh"
module ffs_dither
  import ffs_pkg::*;
#(
  parameter int unsigned RANGE_PM = `FFS_DITHER_RANGE_PM,
  parameter int unsigned STEP_CYCLES = `FFS_DITHER_STEP_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  output logic [`FFS_TRIM_W-1:0] trim_q
);

  logic [31:0] step_q;
  logic [31:0] step_d;
  logic up_q;
  logic up_d;
  logic [`FFS_TRIM_W-1:0] trim_d;

  // Step the trim up to full range, then back to zero
  always_comb begin
    step_d = step_q + 32'h1;
    up_d = up_q;
    trim_d = trim_q;
    if (step_q >= STEP_CYCLES - 1) begin
      step_d = 32'h0;
      if (up_q) begin
        trim_d = trim_q + `FFS_TRIM_W'(1);
        if (trim_d == `FFS_TRIM_W'(RANGE_PM)) begin
          up_d = 1'b0;
        end
      end else begin
        trim_d = trim_q - `FFS_TRIM_W'(1);
        if (trim_d == '0) begin
          up_d = 1'b1;
        end
      end
    end
  end

  // Register dither state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      step_q <= 32'h0;
      up_q <= 1'b1;
      trim_q <= '0;
    end else begin
      step_q <= step_d;
      up_q <= up_d;
      trim_q <= trim_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  dither_span_a:
  assert property (trim_q <= `FFS_TRIM_W'(RANGE_PM))
    else $error("dither out of span");

  dither_step_a:
  assert property ($changed(trim_q) |-> $past(step_q) >= STEP_CYCLES - 1)
    else $error("dither stepped early");

endmodule : ffs_dither

// ---- verilog/ffs_map.svh ----
// Constants for the flyback fault supervisor and dither block
// Functional notes
// - Triangular dither, 5 percent span, 240 Hz
// - Latched option: inhibit until supply power-on reset
// - Auto-restart: retry each startup, refault if present
// - No switching before supply turn-on indication
// - Run until turn-off level or overvoltage lockout
// - Supply overvoltage fault after three cycles
// - Die overtemperature fault after 32 cycles
// - Overtemperature resume on clear; latched needs reset (code restarts only after the supply falls to turn-off)
// - Overpower timer counts up when feedback exceeds ramp
// - Overpower timer counts down below overpower threshold
// - Overpower fault when timer reaches 85 ms
// - Short-circuit fault after eight blanking over-limits
// - Offset current only after brown-in crossed
// - Brown-out needs full continuous qualification time
// - Brown-out qualification time is 45 ms
// - Brown-out clears immediately when pin recovers
// - Variant selects brown-out or overvoltage/overtemperature
// - Pin overvoltage fault after three cycles
// - Pin overtemperature fault after 32 cycles
// - Pin below disable level stops switching immediately
// - Leaving disable has no added delay
// - Turn-off after fault clears all qualifiers
`ifndef FFS_MAP_SVH
`define FFS_MAP_SVH

`define FFS_CLK_HZ 100000000
`define FFS_OVLO_CYCLES 3
`define FFS_DIE_OT_CYCLES 32
`define FFS_SCP_CYCLES 8
`define FFS_FLT_OVP_CYCLES 3
`define FFS_FLT_OT_CYCLES 32
`define FFS_OPP_TIME_MS 85
`define FFS_OPP_CYCLES \
  (32'((64'(`FFS_OPP_TIME_MS) * 64'(`FFS_CLK_HZ)) / 64'd1000))
`define FFS_BO_TIME_MS 45
`define FFS_BO_CYCLES \
  (32'((64'(`FFS_BO_TIME_MS) * 64'(`FFS_CLK_HZ)) / 64'd1000))
`define FFS_DITHER_RATE_HZ 240
`define FFS_DITHER_RANGE_PCT 5
`define FFS_DITHER_RANGE_PM (`FFS_DITHER_RANGE_PCT * 10)
`define FFS_DITHER_STEP_CYCLES \
  (`FFS_CLK_HZ / (`FFS_DITHER_RATE_HZ * 2 * `FFS_DITHER_RANGE_PM))
`define FFS_TRIM_W 8

`endif

// ---- verilog/ffs_pkg.sv ----
// Types and helpers shared by the fault supervisor files
package ffs_pkg;

  // Comparator indications, all synchronous to clk
  typedef struct packed {
    logic vdd_on;        // Supply above turn-on level
    logic vdd_off;       // Supply at or below turn-off level
    logic vdd_ovlo;      // Supply above overvoltage lockout
    logic die_hot;       // Die hot, with hysteresis
    logic fb_above_ramp; // Feedback above on-time ramp
    logic fb_below_opp;  // Feedback below overpower threshold
    logic cs_blank_over; // Current sense over limit in blanking
    logic flt_bi;        // Fault pin above brown-in level
    logic flt_bo;        // Fault pin below brown-out level
    logic flt_ovp;       // Fault pin above overvoltage level
    logic flt_tsd;       // Fault pin below overtemperature level
    logic flt_dis;       // Fault pin below disable level
  } ffs_cmp_t;

  // Fault status flags
  typedef struct packed {
    logic vdd_ovlo;
    logic die_ot;
    logic opp;
    logic scp;
    logic flt_ovp;
    logic flt_ot;
    logic brown_out;
    logic disabled;
  } ffs_fault_t;

  // Supervisor states
  typedef enum logic [1:0] {
    FFS_OFF = 2'b00,
    FFS_RUN = 2'b01,
    FFS_FAULT = 2'b10,
    FFS_LOCK = 2'b11
  } ffs_state_t;

  // Saturating up/down step between zero and a limit
  function automatic logic [31:0] ffs_sat_step(
      input logic [31:0] v, input logic [31:0] lim,
      input logic up, input logic down);
    logic [31:0] r;
    r = v;
    if (up && v < lim) begin
      r = v + 32'h1;
    end else if (!up && down && v != 32'h0) begin
      r = v - 32'h1;
    end
    return r;
  endfunction : ffs_sat_step

endpackage : ffs_pkg

// ---- verilog/ffs_supervisor.sv ----
// Fault supervisor, response state machine and gate enable
`timescale 1ns/1ns
`include "ffs_map.svh"
module ffs_supervisor
  import ffs_pkg::*;
#(
  parameter int unsigned OPP_CYCLES = `FFS_OPP_CYCLES,
  parameter int unsigned BO_CYCLES = `FFS_BO_CYCLES,
  parameter int unsigned DITHER_STEP_CYCLES = `FFS_DITHER_STEP_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire ffs_cmp_t cmp,
  input wire logic sw_cycle,
  input wire logic pwm_fall,
  input wire logic latched_opt,
  input wire logic variant_bo,
  output logic gate_en_q,
  output logic offset_en_q,
  output ffs_fault_t fault_q,
  output ffs_state_t state_q,
  output logic [`FFS_TRIM_W-1:0] trim_q
);

  ffs_state_t state_d;
  ffs_fault_t fault_d;
  logic gate_en_d;
  logic offset_en_d;
  logic qual_clr;
  logic hit_ovlo;
  logic hit_die_ot;
  logic hit_scp;
  logic hit_flt_ovp;
  logic hit_flt_ot;
  logic hard_fault;
  logic bo_block;
  logic [31:0] opp_cnt_q;
  logic [31:0] opp_cnt_d;
  logic opp_up_q;
  logic opp_up_d;
  logic opp_hit;
  logic [31:0] bo_cnt_q;
  logic [31:0] bo_cnt_d;
  logic bo_hit_d;
  logic bo_armed_q;
  logic bo_armed_d;

  // Qualifiers start fresh whenever the supply is off or locked
  assign qual_clr = (state_q == FFS_OFF) || (state_q == FFS_LOCK);

  // Supply overvoltage, three consecutive cycles
  ffs_cycle_qual #(.COUNT(`FFS_OVLO_CYCLES)) u_q_ovlo (
    .clk(clk),
    .sys_rst(sys_rst),
    .clr(qual_clr),
    .tick(sw_cycle),
    .level(cmp.vdd_ovlo),
    .hit_q(hit_ovlo)
  );

  // Die overtemperature, 32 cycles
  ffs_cycle_qual #(.COUNT(`FFS_DIE_OT_CYCLES)) u_q_die (
    .clk(clk),
    .sys_rst(sys_rst),
    .clr(qual_clr),
    .tick(sw_cycle),
    .level(cmp.die_hot),
    .hit_q(hit_die_ot)
  );

  // Short circuit in blanking interval, eight cycles
  ffs_cycle_qual #(.COUNT(`FFS_SCP_CYCLES)) u_q_scp (
    .clk(clk),
    .sys_rst(sys_rst),
    .clr(qual_clr),
    .tick(sw_cycle),
    .level(cmp.cs_blank_over),
    .hit_q(hit_scp)
  );

  // Fault pin overvoltage, only in the overvoltage variant
  ffs_cycle_qual #(.COUNT(`FFS_FLT_OVP_CYCLES)) u_q_fovp (
    .clk(clk),
    .sys_rst(sys_rst),
    .clr(qual_clr),
    .tick(sw_cycle),
    .level(cmp.flt_ovp && !variant_bo),
    .hit_q(hit_flt_ovp)
  );

  // Fault pin overtemperature, only in the overvoltage variant
  ffs_cycle_qual #(.COUNT(`FFS_FLT_OT_CYCLES)) u_q_fot (
    .clk(clk),
    .sys_rst(sys_rst),
    .clr(qual_clr),
    .tick(sw_cycle),
    .level(cmp.flt_tsd && !variant_bo && !cmp.flt_dis),
    .hit_q(hit_flt_ot)
  );

  // Triangular dither of the switching frequency
  ffs_dither #(.STEP_CYCLES(DITHER_STEP_CYCLES)) u_dither (
    .clk(clk),
    .sys_rst(sys_rst),
    .trim_q(trim_q)
  );

  // Overpower up/down timer
  always_comb begin
    opp_up_d = opp_up_q;
    if (qual_clr) begin
      opp_up_d = 1'b0;
    end else if (pwm_fall) begin
      opp_up_d = cmp.fb_above_ramp;
    end
    opp_cnt_d = ffs_sat_step(opp_cnt_q, OPP_CYCLES,
                             opp_up_d, cmp.fb_below_opp);
    if (qual_clr) begin
      opp_cnt_d = 32'h0;
    end
    opp_hit = (opp_cnt_q >= OPP_CYCLES);
  end

  // Brown-out timer and offset current arming
  always_comb begin
    bo_armed_d = bo_armed_q;
    if (qual_clr || !variant_bo) begin
      bo_armed_d = 1'b0;
    end else if (cmp.flt_bi) begin
      bo_armed_d = 1'b1;
    end
    offset_en_d = bo_armed_d && variant_bo;
    bo_cnt_d = 32'h0;
    if (variant_bo && cmp.flt_bo && !qual_clr) begin
      bo_cnt_d = ffs_sat_step(bo_cnt_q, BO_CYCLES, 1'b1, 1'b0);
    end
    bo_hit_d = (bo_cnt_d >= BO_CYCLES);
  end

  // Register overpower and brown-out state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      opp_up_q <= 1'b0;
      opp_cnt_q <= 32'h0;
      bo_armed_q <= 1'b0;
      bo_cnt_q <= 32'h0;
      offset_en_q <= 1'b0;
    end else begin
      opp_up_q <= opp_up_d;
      opp_cnt_q <= opp_cnt_d;
      bo_armed_q <= bo_armed_d;
      bo_cnt_q <= bo_cnt_d;
      offset_en_q <= offset_en_d;
    end
  end

  // Faults that force the fault state, then restart or latch by option
  assign hard_fault = hit_ovlo || hit_die_ot || opp_hit || hit_scp ||
                      hit_flt_ovp || hit_flt_ot;

  // Brown-in not yet seen or brown-out qualified blocks switching
  assign bo_block = variant_bo && (!bo_armed_q || fault_q.brown_out);

  // Response state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      FFS_OFF: begin
        if (cmp.vdd_on && !cmp.vdd_off) begin
          state_d = FFS_RUN;
        end
      end
      FFS_RUN: begin
        if (hard_fault) begin
          state_d = FFS_FAULT;
        end else if (cmp.vdd_off) begin
          state_d = FFS_OFF;
        end
      end
      FFS_FAULT: begin
        if (cmp.vdd_off) begin
          // Latched parts wait for power-on reset
          state_d = latched_opt ? FFS_LOCK : FFS_OFF;
        end
      end
      FFS_LOCK: begin
        state_d = FFS_LOCK;
      end
      default: begin
        state_d = FFS_OFF;
      end
    endcase
  end

  // Fault flags and gate enable
  always_comb begin
    fault_d = fault_q;
    if (qual_clr) begin
      fault_d = '0;
    end
    // New hits win over any clear in the same cycle
    fault_d.vdd_ovlo = fault_d.vdd_ovlo || hit_ovlo;
    fault_d.die_ot = fault_d.die_ot || hit_die_ot;
    fault_d.opp = fault_d.opp || opp_hit;
    fault_d.scp = fault_d.scp || hit_scp;
    fault_d.flt_ovp = fault_d.flt_ovp || hit_flt_ovp;
    fault_d.flt_ot = fault_d.flt_ot || hit_flt_ot;
    fault_d.brown_out = bo_hit_d;
    fault_d.disabled = cmp.flt_dis;
    gate_en_d = (state_d == FFS_RUN) && !hard_fault && !cmp.flt_dis &&
                !(variant_bo && (!bo_armed_d || bo_hit_d));
  end

  // Register state, flags and gate enable
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= FFS_OFF;
      fault_q <= '0;
      gate_en_q <= 1'b0;
    end else begin
      state_q <= state_d;
      fault_q <= fault_d;
      gate_en_q <= gate_en_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  start_gate_a:
  assert property (state_q == FFS_OFF && !cmp.vdd_on |=> !gate_en_q)
    else $error("gate enabled before supply turn-on");

  uvlo_off_a:
  assert property (state_q == FFS_RUN && cmp.vdd_off && !hard_fault
                   |=> state_q == FFS_OFF && !gate_en_q)
    else $error("run state did not end at turn-off level");

  lock_hold_a:
  assert property (state_q == FFS_LOCK |=> state_q == FFS_LOCK && !gate_en_q)
    else $error("latched inhibit released without reset");

  retry_path_a:
  assert property (state_q == FFS_FAULT && cmp.vdd_off && !latched_opt
                   |=> state_q == FFS_OFF ##1 opp_cnt_q == 32'h0)
    else $error("auto-restart did not return to off");

  dis_stop_a:
  assert property (cmp.flt_dis |=> !gate_en_q && fault_q.disabled)
    else $error("disable did not stop switching");

  opp_floor_a:
  assert property (opp_cnt_q == 32'h0 && !opp_up_d |=> opp_cnt_q == 32'h0)
    else $error("overpower timer wrapped below zero");

  opp_trip_a:
  assert property (state_q == FFS_RUN && opp_cnt_q >= OPP_CYCLES
                   |=> state_q == FFS_FAULT && !gate_en_q && fault_q.opp)
    else $error("overpower limit did not trip");

  bo_release_a:
  assert property (fault_q.brown_out && !cmp.flt_bo |=> !fault_q.brown_out)
    else $error("brown-out did not clear at once");

  offset_arm_a:
  assert property (!bo_armed_q && !cmp.flt_bi |=> !offset_en_q)
    else $error("offset current enabled before brown-in");

  ovlo_trip_a:
  assert property (state_q == FFS_RUN && hit_ovlo |=> state_q == FFS_FAULT)
    else $error("supply overvoltage did not enter fault");

  bo_gate_a:
  assert property (bo_block |-> !gate_en_q)
    else $error("gate enabled while brown-out blocks it");

  die_trip_a:
  assert property (state_q == FFS_RUN && hit_die_ot
                   |=> state_q == FFS_FAULT && fault_q.die_ot && !gate_en_q)
    else $error("die overtemperature did not stop switching");

  scp_trip_a:
  assert property (state_q == FFS_RUN && hit_scp
                   |=> state_q == FFS_FAULT && fault_q.scp && !gate_en_q)
    else $error("short circuit did not stop switching");

  fovp_trip_a:
  assert property (state_q == FFS_RUN && hit_flt_ovp
                   |=> state_q == FFS_FAULT && fault_q.flt_ovp && !gate_en_q)
    else $error("fault pin overvoltage did not stop switching");

  fot_trip_a:
  assert property (state_q == FFS_RUN && hit_flt_ot
                   |=> state_q == FFS_FAULT && fault_q.flt_ot && !gate_en_q)
    else $error("fault pin overtemperature did not stop switching");

  bo_trip_a:
  assert property (variant_bo && bo_hit_d
                   |=> fault_q.brown_out && !gate_en_q)
    else $error("qualified brown-out did not stop switching");

  bo_glitch_a:
  assert property (!cmp.flt_bo |=> bo_cnt_q == 32'h0)
    else $error("brown-out timer kept time across a glitch");

  clear_all_a:
  assert property (qual_clr
                   |=> opp_cnt_q == 32'h0 && bo_cnt_q == 32'h0 && !opp_up_q)
    else $error("qualification state not cleared at turn-off");

  opp_up_a:
  assert property (!qual_clr && pwm_fall && cmp.fb_above_ramp &&
                   opp_cnt_q < OPP_CYCLES
                   |=> opp_cnt_q == $past(opp_cnt_q) + 32'h1)
    else $error("overpower timer did not count up");

  opp_down_a:
  assert property (!qual_clr && !opp_up_d && cmp.fb_below_opp &&
                   opp_cnt_q != 32'h0
                   |=> opp_cnt_q == $past(opp_cnt_q) - 32'h1)
    else $error("overpower timer did not count down");

  run_gate_a:
  assert property (gate_en_q |-> state_q == FFS_RUN)
    else $error("gate enabled outside run state");

  lock_entry_a:
  assert property (state_q == FFS_FAULT && cmp.vdd_off && latched_opt
                   |=> state_q == FFS_LOCK)
    else $error("latched option did not lock after fault");

  fault_stop_a:
  assert property (state_q == FFS_FAULT |-> !gate_en_q)
    else $error("gate enabled in fault state");

  variant_gate_a:
  assert property (variant_bo |=> !hit_flt_ovp && !hit_flt_ot)
    else $error("pin overvoltage or overtemperature in brown-out part");

  offset_var_a:
  assert property (!variant_bo |=> !offset_en_q)
    else $error("offset current enabled in overvoltage part");

  dis_exit_a:
  assert property (fault_q.disabled && !cmp.flt_dis && !hard_fault &&
                   state_d == FFS_RUN && !variant_bo
                   |=> gate_en_q && !fault_q.disabled)
    else $error("leaving disable was delayed");

  sticky_opp_a:
  assert property (fault_q.opp && !qual_clr |=> fault_q.opp)
    else $error("overpower fault dropped before turn-off");

  offset_on_a:
  assert property (variant_bo && cmp.flt_bi && !qual_clr |=> offset_en_q)
    else $error("offset current not enabled after brown-in");

  lock_seen_c: cover property (state_q == FFS_FAULT ##1 state_q == FFS_LOCK);
  retry_seen_c: cover property (state_q == FFS_OFF ##1 state_q == FFS_RUN
                                ##1 gate_en_q);
  opp_seen_c: cover property ($rose(fault_q.opp));
  bo_seen_c: cover property ($fell(fault_q.brown_out) ##1 gate_en_q);

endmodule : ffs_supervisor
